//--- core/fdsc_top.sv
// Finger detect scan control: resets, detection scan, lift check, stream
//
// What this block does
// RULE1 - Pin, software command or chip enable reset core
// RULE2 - Only the pin resets the SPI state machine
// RULE3 - Detection runs only while detect enable set
// RULE4 - Interrupt pin driven only while interrupt enabled
// RULE5 - Detection sums selected row, pushes no data
// RULE6 - Sum above threshold at row end raises flag
// RULE7 - Detection OK flag opens image channel
// RULE8 - Sum not above threshold clears flag, closes channel
// RULE9 - Flag updated per detection, cleared at scan start
// RULE10 - OK flag changes at detection end; reset clears (the code also clears it at a lift check row end)
// RULE11 - Lift row below threshold makes later rows white
// RULE12 - Departure raises interrupt pin, clears both flags
// RULE13 - Pin idles high, falls on touch, rises on lift
// RULE14 - Cold start latency is 180 pixel clocks
// RULE15 - Later scans start after 19 pixel clocks
// RULE16 - One pixel sample per pixel clock
// RULE17 - Eleven pixel clock gap between image rows
// RULE18 - Host resets, initialises, waits detection before capture
// RULE19 - Image scan with channel closed reads white
// RULE20 - Total gain is product of two stage ratios
// RULE21 - Offset bit 7 selects negative compensation
// RULE22 - Trim code sets oscillator frequency per table
// RULE23 - Detection repeat interval is a fixed parameter
`timescale 1ns/1ps
`include "fdsc_consts.svh"
module fdsc_top
   import fdsc_pkg::*;
#(
   parameter int PIX_PER_ROW = `FDSC_ROW_PIX,
   parameter int ROWS = `FDSC_ROWS,
   parameter int DET_INTERVAL = `FDSC_DET_INTERVAL
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Reset sources
   input wire logic hw_rst_pin_n,
   input wire logic sw_reset_cmd,
   input wire logic chip_en,
   // Control bits
   input wire logic det_en,
   input wire logic intr_en,
   input wire logic start_img,
   input wire logic [7:0] detect_row_select,
   input wire logic [7:0] lift_check_row_select,
   input wire logic [15:0] detect_threshold,
   // Analog setup codes
   input wire logic [1:0] first_stage_gain,
   input wire logic [3:0] second_stage_gain,
   input wire logic [7:0] dc_offset,
   input wire logic [5:0] osc_trim,
   // Pixel link from the front end
   input wire logic pclk,
   input wire logic [7:0] pix_in,
   output logic [7:0] row_addr_ff,
   // Image stream
   output logic img_valid,
   input wire logic img_ready,
   output logic [7:0] img_data,
   // Status and resets
   output logic det_irq_ff,
   output logic det_ok_ff,
   output logic core_rst_ff,
   output logic spi_rst_ff,
   output logic busy_ff,
   // Finger interrupt pin
   output logic finger_irq_pin_o_ff,
   output logic finger_irq_pin_oe_ff,
   // Analog setup outputs
   output logic [20:0] total_gain_x10k_ff,
   output logic dc_comp_neg_ff,
   output logic [6:0] dc_comp_mag_ff,
   output logic [11:0] osc_freq_10khz_ff
);
   // ****************************************************************
   // Lookup functions
   // ****************************************************************
   function automatic logic [9:0] g1_x100(input logic [1:0] c);
      unique case (c)
         2'h0: g1_x100 = 10'd200;
         2'h1: g1_x100 = 10'd267;
         2'h2: g1_x100 = 10'd400;
         2'h3: g1_x100 = 10'd800;
      endcase
   endfunction : g1_x100

   function automatic logic [10:0] g2_x100(input logic [3:0] c);
      logic [10:0] t [16];
      t = '{11'd188, 11'd356, 11'd376, 11'd400, 11'd427, 11'd457,
            11'd492, 11'd533, 11'd582, 11'd640, 11'd711, 11'd800,
            11'd914, 11'd1067, 11'd1280, 11'd1600};
      g2_x100 = t[c];
   endfunction : g2_x100

   // Oscillator in 10 kHz units; slot is code bits 5 to 1, bit 0 ignored
   function automatic logic [11:0] osc_freq(input logic [5:0] c);
      logic [11:0] t [32];
      t = '{12'd2366, 12'd1552, 12'd1786, 12'd1260, 12'd1947, 12'd1345,
            12'd1530, 12'd1121, 12'd2047, 12'd1395, 12'd1587, 12'd1151,
            12'd1716, 12'd1223, 12'd1377, 12'd1033, 12'd2070, 12'd1405,
            12'd1601, 12'd1158, 12'd1733, 12'd1231, 12'd1388, 12'd1038,
            12'd1815, 12'd1275, 12'd1436, 12'd1066, 12'd1545, 12'd1128,
            12'd1260, 12'd963};
      osc_freq = t[c[5:1]];
   endfunction : osc_freq

   initial begin
      if (PIX_PER_ROW < 2 || PIX_PER_ROW > 256)
         $error("fdsc_top: PIX_PER_ROW out of range");
      if (ROWS < 1 || ROWS > 256)
         $error("fdsc_top: ROWS out of range");
      if (DET_INTERVAL < 1 || DET_INTERVAL > 255)
         $error("fdsc_top: DET_INTERVAL out of range");
   end

   // ****************************************************************
   // Synchronisers and reset tree
   // ****************************************************************
   logic hw_s1_ff;
   logic hw_s2_ff;
   logic pclk_s1_ff;
   logic pclk_s2_ff;
   logic pclk_s3_ff;
   logic [7:0] pix_s1_ff;
   logic [7:0] pix_s2_ff;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         hw_s1_ff <= 1'b0;
         hw_s2_ff <= 1'b0;
         pclk_s1_ff <= 1'b0;
         pclk_s2_ff <= 1'b0;
         pclk_s3_ff <= 1'b0;
         pix_s1_ff <= 8'h00;
         pix_s2_ff <= 8'h00;
      end else begin
         hw_s1_ff <= hw_rst_pin_n;
         hw_s2_ff <= hw_s1_ff;
         pclk_s1_ff <= pclk;
         pclk_s2_ff <= pclk_s1_ff;
         pclk_s3_ff <= pclk_s2_ff;
         pix_s1_ff <= pix_in;
         pix_s2_ff <= pix_s1_ff;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         core_rst_ff <= 1'b1;
         spi_rst_ff <= 1'b1;
      end else begin
         core_rst_ff <= !hw_s2_ff || sw_reset_cmd || !chip_en; // [RULE1]
         spi_rst_ff <= !hw_s2_ff; // [RULE2]
      end
   end

   // ****************************************************************
   // Scan sequencer
   // ****************************************************************
   fdsc_state_e state_ff;
   logic [7:0] cnt_ff;
   logic [7:0] row_ff;
   logic [15:0] sum_ff;
   logic mode_det_ff;
   logic warm_ff;
   logic white_ff;
   logic start_req_ff;
   logic det_en_d_ff;
   logic buf_in_ready;
   logic tick;
   logic row_end;
   logic push;
   logic scan_start;
   logic go_img;
   logic go_det;
   logic finger_on;
   logic finger_off;
   logic lift;
   logic [15:0] nxt_sum;
   logic [7:0] lat;

   // A full buffer holds the sequencer back so no word is dropped
   assign tick = pclk_s2_ff && !pclk_s3_ff && buf_in_ready; // [RULE16]
   assign nxt_sum = sum_ff + {8'h00, pix_s2_ff};
   assign row_end = tick && state_ff == ST_ROW
                    && cnt_ff == 8'(PIX_PER_ROW - 1);
   assign push = tick && state_ff == ST_ROW && !mode_det_ff; // [RULE5]
   assign go_img = start_req_ff;
   assign go_det = det_en && !start_req_ff; // [RULE3]
   // A dropped detect enable in the wait slot aborts first; image starts later
   assign scan_start = tick && !core_rst_ff
                       && (state_ff == ST_IDLE && (go_img || go_det)
                          || state_ff == ST_WAIT && cnt_ff == 8'h00 && det_en);
   assign lat = warm_ff ? `FDSC_LAT_WARM : `FDSC_LAT_COLD; // [RULE14] [RULE15]
   assign finger_on = row_end && mode_det_ff
                      && nxt_sum > detect_threshold; // [RULE6]
   assign finger_off = row_end && mode_det_ff
                       && !(nxt_sum > detect_threshold); // [RULE8]
   assign lift = row_end && !mode_det_ff && row_ff == lift_check_row_select
                 && nxt_sum < detect_threshold; // [RULE11]

   always_ff @(posedge sys_clk) begin
      if (core_rst_ff) begin
         start_req_ff <= 1'b0;
      end else if (start_img) begin
         start_req_ff <= 1'b1;
      end else if (scan_start && go_img) begin
         start_req_ff <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (core_rst_ff) begin
         det_en_d_ff <= 1'b0;
         warm_ff <= 1'b0;
      end else begin
         det_en_d_ff <= det_en;
         if (det_en_d_ff && !det_en)
            warm_ff <= 1'b0; // [RULE14]
         else if (scan_start)
            warm_ff <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (core_rst_ff) begin
         state_ff <= ST_IDLE;
         cnt_ff <= 8'h00;
         row_ff <= 8'h00;
         sum_ff <= 16'h0000;
         mode_det_ff <= 1'b0;
         white_ff <= 1'b0;
      end else if (mode_det_ff && !det_en && state_ff != ST_IDLE) begin
         state_ff <= ST_IDLE; // [RULE3]
      end else if (scan_start) begin
         state_ff <= ST_LEAD;
         cnt_ff <= lat - 8'd1;
         row_ff <= 8'h00;
         mode_det_ff <= !go_img;
         white_ff <= 1'b0;
      end else if (tick) begin
         unique case (state_ff)
            ST_IDLE: begin
               state_ff <= ST_IDLE;
            end
            ST_LEAD, ST_GAP: begin
               if (cnt_ff == 8'h00) begin
                  state_ff <= ST_ROW;
                  sum_ff <= 16'h0000;
               end else begin
                  cnt_ff <= cnt_ff - 8'd1;
               end
            end
            ST_ROW: begin
               sum_ff <= nxt_sum; // [RULE5]
               if (lift)
                  white_ff <= 1'b1; // [RULE11]
               if (!row_end) begin
                  cnt_ff <= cnt_ff + 8'd1;
               end else if (mode_det_ff) begin
                  state_ff <= ST_WAIT;
                  cnt_ff <= 8'(DET_INTERVAL - 1); // [RULE23]
               end else if (row_ff != 8'(ROWS - 1)) begin
                  state_ff <= ST_GAP;
                  cnt_ff <= `FDSC_ROW_GAP - 8'd1; // [RULE17]
                  row_ff <= row_ff + 8'd1;
               end else begin
                  state_ff <= ST_IDLE;
               end
            end
            ST_WAIT: begin
               if (cnt_ff != 8'h00)
                  cnt_ff <= cnt_ff - 8'd1;
               else
                  state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (core_rst_ff) begin
         row_addr_ff <= 8'h00;
         busy_ff <= 1'b0;
      end else begin
         row_addr_ff <= mode_det_ff ? detect_row_select : row_ff; // [RULE5]
         busy_ff <= state_ff != ST_IDLE;
      end
   end

   // ****************************************************************
   // Status flags and interrupt pin
   // ****************************************************************
   always_ff @(posedge sys_clk) begin
      if (core_rst_ff) begin
         det_irq_ff <= 1'b0; // [RULE10]
         det_ok_ff <= 1'b0;
      end else if (finger_on) begin
         det_irq_ff <= 1'b1; // [RULE6] [RULE9]
         det_ok_ff <= 1'b1; // [RULE10]
      end else if (finger_off || lift) begin
         det_irq_ff <= 1'b0; // [RULE8] [RULE12]
         det_ok_ff <= 1'b0;
      end else if (scan_start) begin
         det_irq_ff <= 1'b0; // [RULE9]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (core_rst_ff) begin
         finger_irq_pin_o_ff <= `FDSC_PIN_IDLE;
         finger_irq_pin_oe_ff <= 1'b0;
      end else begin
         finger_irq_pin_oe_ff <= intr_en; // [RULE4]
         if (!intr_en)
            finger_irq_pin_o_ff <= `FDSC_PIN_IDLE; // [RULE13]
         else if (finger_on)
            finger_irq_pin_o_ff <= 1'b0; // [RULE13]
         else if (lift)
            finger_irq_pin_o_ff <= 1'b1; // [RULE12]
      end
   end

   // ****************************************************************
   // Image channel and analog setup
   // ****************************************************************
   fdsc_byte_t pix_out;

   // Closed channel or a lifted finger yields white pixels
   assign pix_out = (!det_ok_ff || white_ff) ? `FDSC_WHITE_PIX
                    : pix_s2_ff; // [RULE7] [RULE19] [RULE11]

   fdsc_buf2 #(
      .W(8)
   ) u_buf (
      .clk(sys_clk),
      .rst(core_rst_ff),
      .in_valid(push),
      .in_ready(buf_in_ready),
      .in_data(pix_out),
      .out_valid(img_valid),
      .out_ready(img_ready),
      .out_data(img_data)
   );

   always_ff @(posedge sys_clk) begin
      if (core_rst_ff) begin
         total_gain_x10k_ff <= 21'h00000;
         dc_comp_neg_ff <= 1'b0;
         dc_comp_mag_ff <= 7'h00;
         osc_freq_10khz_ff <= 12'h000;
      end else begin
         total_gain_x10k_ff <= 21'(g1_x100(first_stage_gain)
                               * g2_x100(second_stage_gain)); // [RULE20]
         dc_comp_neg_ff <= dc_offset[`FDSC_DCOFS_SIGN_BIT]; // [RULE21]
         dc_comp_mag_ff <= dc_offset[6:0];
         osc_freq_10khz_ff <= osc_freq(osc_trim); // [RULE22]
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   property p_sw_reset_core;
      @(posedge sys_clk) disable iff (reset)
      (sw_reset_cmd || !chip_en) |=> core_rst_ff ##1 !busy_ff;
   endproperty
   a_sw_reset_core: assert property (p_sw_reset_core) // [RULE1]
      else $error("soft reset source did not reset the core");

   property p_spi_kept;
      @(posedge sys_clk) disable iff (reset)
      (hw_s2_ff && (sw_reset_cmd || !chip_en)) |=> !spi_rst_ff;
   endproperty
   a_spi_kept: assert property (p_spi_kept) // [RULE2]
      else $error("SPI reset followed a soft reset source");

   property p_det_needs_en;
      @(posedge sys_clk) disable iff (reset)
      (!det_en && !core_rst_ff) |=> ##1 !(mode_det_ff && busy_ff);
   endproperty
   a_det_needs_en: assert property (p_det_needs_en) // [RULE3]
      else $error("detection scan ran with detect enable low");

   property p_pin_oe;
      @(posedge sys_clk) disable iff (reset)
      !intr_en |=> !finger_irq_pin_oe_ff;
   endproperty
   a_pin_oe: assert property (p_pin_oe) // [RULE4]
      else $error("interrupt pin driven while disabled");

   property p_det_no_push;
      @(posedge sys_clk) disable iff (reset)
      (mode_det_ff && !img_valid) |=> !img_valid;
   endproperty
   a_det_no_push: assert property (p_det_no_push) // [RULE5]
      else $error("detection scan pushed image data");

   property p_finger_on;
      @(posedge sys_clk) disable iff (reset)
      (!core_rst_ff && row_end && mode_det_ff
       && nxt_sum > detect_threshold) |=> det_irq_ff && det_ok_ff;
   endproperty
   a_finger_on: assert property (p_finger_on) // [RULE6]
      else $error("sum above threshold did not raise flags");

   property p_finger_off;
      @(posedge sys_clk) disable iff (reset)
      (row_end && mode_det_ff && nxt_sum <= detect_threshold)
      |=> !det_irq_ff && !det_ok_ff;
   endproperty
   a_finger_off: assert property (p_finger_off) // [RULE8]
      else $error("low sum did not clear flags");

   property p_start_clears;
      @(posedge sys_clk) disable iff (reset)
      scan_start |=> !det_irq_ff && state_ff == ST_LEAD;
   endproperty
   a_start_clears: assert property (p_start_clears) // [RULE9]
      else $error("scan start did not clear detection flag");

   property p_row_gap;
      @(posedge sys_clk) disable iff (reset)
      (!core_rst_ff && row_end && !mode_det_ff && row_ff != 8'(ROWS - 1))
      |=> state_ff == ST_GAP && cnt_ff == 8'd10;
   endproperty
   a_row_gap: assert property (p_row_gap) // [RULE17]
      else $error("row gap not loaded with eleven cycles");

   property p_pin_fall;
      @(posedge sys_clk) disable iff (reset)
      (!core_rst_ff && intr_en && finger_on) |=> !finger_irq_pin_o_ff;
   endproperty
   a_pin_fall: assert property (p_pin_fall) // [RULE13]
      else $error("interrupt pin did not fall on touch");
endmodule : fdsc_top

//--- core/fdsc_consts.svh
// Timing counts, field positions and reset values of the scan control
`ifndef FDSC_CONSTS_SVH
`define FDSC_CONSTS_SVH

// ****************************************************************
// Timing in pixel clock cycles
// ****************************************************************
`define FDSC_LAT_COLD 8'd180
`define FDSC_LAT_WARM 8'd19
`define FDSC_ROW_GAP 8'd11
`define FDSC_ROW_PIX 192
`define FDSC_ROWS 256
`define FDSC_DET_INTERVAL 64

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define FDSC_DCOFS_SIGN_BIT 7
`define FDSC_WHITE_PIX 8'hFF
`define FDSC_PIN_IDLE 1'b1

`endif

//--- core/fdsc_pkg.sv
// Types shared by the finger detect scan control
package fdsc_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_LEAD,
      ST_ROW,
      ST_GAP,
      ST_WAIT
   } fdsc_state_e;

   typedef logic [7:0] fdsc_byte_t;
endpackage : fdsc_pkg

//--- core/fdsc_buf2.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module fdsc_buf2 #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   logic main_v_ff;
   logic skid_v_ff;
   logic [W-1:0] main_d_ff;
   logic [W-1:0] skid_d_ff;

   initial begin
      if (W < 1) $error("fdsc_buf2: W must be at least 1");
   end

   assign in_ready = !skid_v_ff;
   assign out_valid = main_v_ff;
   assign out_data = main_d_ff;

   // Head word moves on when drained, the second slot catches a stall
   always_ff @(posedge clk) begin
      if (rst) begin
         main_v_ff <= 1'b0;
         skid_v_ff <= 1'b0;
         main_d_ff <= '0;
         skid_d_ff <= '0;
      end else if (out_ready || !main_v_ff) begin
         if (skid_v_ff) begin
            main_d_ff <= skid_d_ff;
            main_v_ff <= 1'b1;
            skid_v_ff <= 1'b0;
         end else begin
            main_d_ff <= in_data;
            main_v_ff <= in_valid;
         end
      end else if (in_valid && !skid_v_ff) begin
         skid_d_ff <= in_data;
         skid_v_ff <= 1'b1;
      end
   end
endmodule : fdsc_buf2

//--- testbench/fdsc_pix_model.sv
// Pixel front end model: link clock and pixel bytes
`timescale 1ns/1ps
module fdsc_pix_model (
   // Bench control
   input wire logic run,
   input wire logic finger,
   // Link to the block
   output logic pclk,
   output logic [7:0] pix
);
   // Clock stands still while run is low; bytes change after the fall
   initial begin
      pclk = 1'b0;
      pix = 8'h00;
      #7;
      forever begin
         #160;
         if (run) begin
            pclk = ~pclk;
            if (!pclk) pix = finger ? 8'h20 : 8'h00;
         end
      end
   end
endmodule : fdsc_pix_model

//--- testbench/tb_top.sv
// Self-checking bench of the finger detect scan control
`timescale 1ns/1ps
module tb_top;
   import fdsc_pkg::*;
   localparam int NPIX = 8;
   localparam int NROW = 4;
   localparam int NB = NPIX * NROW;
   localparam logic [5:0] GC [3] = '{6'h00, 6'h13, 6'h3F};
   localparam int GX [3] = '{37600, 106800, 1280000};
   localparam logic [5:0] OC [3] = '{6'h00, 6'h20, 6'h3E};
   localparam int OF [3] = '{2366, 2070, 963};
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic hw_rst_pin_n = 1'b1;
   logic sw_reset_cmd = 1'b0;
   logic chip_en = 1'b1;
   logic det_en = 1'b0;
   logic intr_en = 1'b0;
   logic start_img = 1'b0;
   logic [15:0] thr = 16'h00FF;
   logic [1:0] g1 = 2'h0;
   logic [3:0] g2 = 4'h0;
   logic [7:0] dco = 8'h00;
   logic [5:0] trim = 6'h00;
   logic finger = 1'b1;
   logic img_ready = 1'b1;
   logic stall = 1'b0;
   logic pclk, img_valid, det_irq_ff, det_ok_ff, core_rst_ff, spi_rst_ff;
   logic irq_o, irq_oe, dc_comp_neg_ff, busy;
   logic [7:0] pix, img_data, row_addr;
   logic [6:0] dc_comp_mag_ff;
   logic [20:0] total_gain_x10k_ff;
   logic [11:0] osc_freq_10khz_ff;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cyc = 0;
   int tick_n = 0;
   logic [7:0] q[$];
   int tq[$];

   always #20 sys_clk = ~sys_clk;
   always @(posedge pclk) tick_n++;
   always @(negedge sys_clk) img_ready <= !(stall && cyc[1:0] == 2'h0);

   fdsc_pix_model u_fe (.run(1'b1), .finger(finger), .pclk(pclk), .pix(pix));

   fdsc_top #(.PIX_PER_ROW(NPIX), .ROWS(NROW), .DET_INTERVAL(2)) DUT (
      .sys_clk(sys_clk), .reset(reset), .hw_rst_pin_n(hw_rst_pin_n),
      .sw_reset_cmd(sw_reset_cmd), .chip_en(chip_en), .det_en(det_en),
      .intr_en(intr_en), .start_img(start_img),
      .detect_row_select(8'h01), .lift_check_row_select(8'h02),
      .detect_threshold(thr), .first_stage_gain(g1),
      .second_stage_gain(g2), .dc_offset(dco), .osc_trim(trim),
      .pclk(pclk), .pix_in(pix), .row_addr_ff(row_addr), .img_valid(img_valid),
      .img_ready(img_ready), .img_data(img_data), .det_irq_ff(det_irq_ff),
      .det_ok_ff(det_ok_ff), .core_rst_ff(core_rst_ff),
      .spi_rst_ff(spi_rst_ff), .busy_ff(busy), .finger_irq_pin_o_ff(irq_o),
      .finger_irq_pin_oe_ff(irq_oe),
      .total_gain_x10k_ff(total_gain_x10k_ff),
      .dc_comp_neg_ff(dc_comp_neg_ff), .dc_comp_mag_ff(dc_comp_mag_ff),
      .osc_freq_10khz_ff(osc_freq_10khz_ff));

   // ****************************************************************
   // Stream collector and hang guard
   // ****************************************************************
   always @(posedge sys_clk) begin
      cyc++;
      if (img_valid === 1'b1 && img_ready === 1'b1) begin
         q.push_back(img_data);
         tq.push_back(tick_n);
      end
      if (cyc == 60000) begin
         n_mismatch++;
         summarize();
      end
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic summarize();
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : tick

   task automatic start_scan();
      @(negedge sys_clk);
      q.delete();
      tq.delete();
      tick_n = 0;
      start_img = 1'b1;
      @(negedge sys_clk);
      start_img = 1'b0;
   endtask : start_scan

   task automatic wait_q(input int n);
      for (int k = 0; k < 20000 && q.size() < n; k++) @(negedge sys_clk);
   endtask : wait_q

   task automatic wait_ok(input logic v);
      for (int k = 0; k < 8000 && det_ok_ff !== v; k++) @(negedge sys_clk);
   endtask : wait_ok

   task automatic chk_bytes(input int a, input int n, input logic [7:0] e);
      for (int i = a; i < a + n; i++) chk(q[i], e);
   endtask : chk_bytes

   // ****************************************************************
   // Test sequence
   // ****************************************************************
   initial begin
      tick(20);
      reset = 1'b0;
      tick(6);
      chk({core_rst_ff, det_irq_ff, det_ok_ff, irq_oe}, 0);
      for (int i = 0; i < 3; i++) begin
         {g1, g2} = GC[i];
         trim = OC[i];
         dco = {i[0], 7'h05};
         tick(3);
         chk(total_gain_x10k_ff, GX[i]);
         chk(osc_freq_10khz_ff, OF[i]);
         chk({dc_comp_neg_ff, dc_comp_mag_ff}, {i[0], 7'h05});
      end
      // Cold then warm image with channel closed
      start_scan();
      wait_q(NB);
      tick(200);
      chk(tq[0] >= 179 && tq[0] <= 184, 1);
      chk_bytes(0, NB, 8'hFF);
      chk(q.size(), NB);
      chk(tq[1] - tq[0], 1);
      chk(tq[NPIX] - tq[NPIX - 1], 12);
      start_scan();
      wait_q(1);
      chk(tq[0] >= 18 && tq[0] <= 23, 1);
      wait_q(NB);
      tick(200);
      // Detection with finger present, then threshold equal to sum
      det_en = 1'b1;
      intr_en = 1'b1;
      tick(2);
      chk({irq_oe, irq_o}, 2'b11);
      q.delete();
      wait_ok(1'b1);
      tick(1);
      chk({det_irq_ff, det_ok_ff, irq_o}, 3'b110);
      chk({busy, row_addr}, 9'h101);
      thr = 16'h0100;
      wait_ok(1'b0);
      chk({det_irq_ff, det_ok_ff}, 0);
      chk(q.size(), 0);
      intr_en = 1'b0;
      tick(2);
      chk({irq_oe, irq_o}, 2'b01);
      intr_en = 1'b1;
      thr = 16'h00FF;
      wait_ok(1'b1);
      // Each reset source in turn
      for (int s = 0; s < 3; s++) begin
         sw_reset_cmd = (s == 0);
         chip_en = (s != 1);
         hw_rst_pin_n = (s != 2);
         tick(4);
         chk({core_rst_ff, det_ok_ff}, 2'b10);
         chk(spi_rst_ff, s == 2);
         sw_reset_cmd = 1'b0;
         chip_en = 1'b1;
         hw_rst_pin_n = 1'b1;
         tick(8);
      end
      // Image with channel open, receiver stalling
      wait_ok(1'b1);
      stall = 1'b1;
      start_scan();
      wait_q(1);
      chk({det_irq_ff, irq_o}, 0);
      wait_q(NB);
      tick(40);
      chk_bytes(0, NB, 8'h20);
      // Finger lifts during image
      wait_ok(1'b1);
      start_scan();
      wait_q(1);
      finger = 1'b0;
      wait_q(NB);
      tick(4);
      chk_bytes(NPIX * 3, NPIX, 8'hFF);
      chk({det_irq_ff, det_ok_ff, irq_o}, 3'b001);
      // Detection off stops scanning and makes the next image cold
      det_en = 1'b0;
      tick(3);
      chk(busy, 1'b0);
      start_scan();
      wait_q(1);
      chk(tq[0] >= 179 && tq[0] <= 184, 1);
      summarize();
   end
endmodule : tb_top
